//--- hw/pwo_pkg.sv
// Constants, register map and carrier types of the pressure window/offset/status bank
package pwo_pkg;

  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam int CLOCK_MHZ = 100;
  localparam int STRETCH_1_US = 16000;
  localparam int STRETCH_2_US = 64000;
  localparam int STRETCH_3_US = 256000;
  localparam int STRETCH_1_CYCLES = STRETCH_1_US * CLOCK_MHZ;
  localparam int STRETCH_2_CYCLES = STRETCH_2_US * CLOCK_MHZ;
  localparam int STRETCH_3_CYCLES = STRETCH_3_US * CLOCK_MHZ;
  localparam int DSP_REINIT_CYCLES = 64;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_IRQ_CONFIG = 8'h45;
  localparam logic [7:0] ADDR_UPPER_LIMIT_LOW = 8'h46;
  localparam logic [7:0] ADDR_UPPER_LIMIT_HIGH = 8'h47;
  localparam logic [7:0] ADDR_LOWER_LIMIT_LOW = 8'h48;
  localparam logic [7:0] ADDR_LOWER_LIMIT_HIGH = 8'h49;
  localparam logic [7:0] ADDR_OFFSET_TRIM_LOW = 8'h4C;
  localparam logic [7:0] ADDR_OFFSET_TRIM_HIGH = 8'h4D;
  localparam logic [7:0] ADDR_DSP_FLAGS = 8'h60;
  localparam logic [7:0] ADDR_EVENT_STATUS = 8'h70;
  localparam logic [7:0] ADDR_EVENT_ENABLE = 8'h71;
  localparam logic [7:0] ADDR_EVENT_CLEAR = 8'h72;

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int CFG_STRETCH_LSB = 4;
  localparam int CFG_SENSE_BIT = 3;
  localparam int FLAG_NEVER_RUN = 3;
  localparam int FLAG_RUNNING = 2;
  localparam int FLAG_CM_FAULT = 1;
  localparam int FLAG_ST_FAILURE = 0;
  localparam int EV_WINDOW = 0;
  localparam int EV_CM_FAULT = 1;
  localparam int EV_ST_FAILURE = 2;
  localparam int EV_LOCKED_WRITE = 3;
  localparam int EV_ARRAY_ERROR = 4;
  localparam int EVENT_COUNT = 5;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] RESET_CONFIG = 8'h00;
  localparam logic [7:0] RESET_DSP_FLAGS = 8'h08;
  localparam logic [15:0] LIMIT_OFF = 16'h0000;

  // ------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------
  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] pressure;
  } sample_t;

endpackage : pwo_pkg

//--- hw/pressure_window_offset_status.sv
// Pressure window comparator, offset trim, write lock and DSP status flags
//
// Summary of operation
// R1: Limit and trim writes blocked after init done
// R2: Limit and trim registers under array checking
// R3: Two unsigned 16-bit limits, low/high bytes
// R4: Zero limit skips only that comparison
// R5: Both limits zero keeps interrupt off
// R6: Signed trim added to calibrated pressure
// R7: Trim change resets DSP path, result invalid
// R8: Host avoids result reads during reinit
// R9: Host picks trim avoiding compression or rail
// R10: Never-run flag set at reset, cleared by self-test
// R11: Running flag is OR of control bits
// R12: Common-mode excursion sets fault flag
// R13: Fault clears on status read or report
// R14: Self-test failure sticky until reset
// R15: Flags reset to 08h, limits and trim zero
// R16: Sense bit selects outside or inside window
// R17: Stretch zero follows sample, else counter
// R18: Outside means above upper or below lower
// R19: Status writes ignored, bits 7:4 read zero
`timescale 1ns/100ps

module pressure_window_offset_status #(
  parameter int STRETCH_1 = pwo_pkg::STRETCH_1_CYCLES,
  parameter int STRETCH_2 = pwo_pkg::STRETCH_2_CYCLES,
  parameter int STRETCH_3 = pwo_pkg::STRETCH_3_CYCLES,
  parameter int REINIT_CYCLES = pwo_pkg::DSP_REINIT_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire pwo_pkg::reg_req_t i_req,
  output logic [7:0] o_rdata,
  input wire logic i_init_done,
  input wire logic [3:0] i_selftest_control,
  input wire logic i_selftest_fail,
  input wire logic i_cm_out_of_limits,
  input wire logic i_status_read_other,
  input wire logic i_tx_reported_cm,
  input wire pwo_pkg::sample_t i_sample,
  output logic [15:0] o_sensor_result,
  output logic o_result_valid,
  output logic o_dsp_path_reset,
  output logic o_interrupt_pin,
  output logic o_array_error,
  output logic o_irq
);

  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------
  logic [7:0] irq_config_reg;
  logic [15:0] upper_limit_reg;
  logic [15:0] lower_limit_reg;
  logic [15:0] offset_trim_reg;
  logic [15:0] offset_trim_next;
  logic [7:0] check_reg;
  logic [7:0] check_next;
  logic selftest_never_run_reg;
  logic common_mode_fault_reg;
  logic selftest_failure_reg;
  logic selftest_running;
  logic [pwo_pkg::EVENT_COUNT-1:0] event_status_reg;
  logic [pwo_pkg::EVENT_COUNT-1:0] event_enable_reg;
  logic [pwo_pkg::EVENT_COUNT-1:0] event_set;
  logic [pwo_pkg::EVENT_COUNT-1:0] event_clear;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // ------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------
  logic wr_cfg;
  logic wr_trim_lo;
  logic wr_trim_hi;
  logic locked_target;
  logic write_open;
  logic locked_write;
  logic trim_changed;

  assign locked_target = (i_req.addr == pwo_pkg::ADDR_UPPER_LIMIT_LOW)
                      || (i_req.addr == pwo_pkg::ADDR_UPPER_LIMIT_HIGH)
                      || (i_req.addr == pwo_pkg::ADDR_LOWER_LIMIT_LOW)
                      || (i_req.addr == pwo_pkg::ADDR_LOWER_LIMIT_HIGH)
                      || (i_req.addr == pwo_pkg::ADDR_OFFSET_TRIM_LOW)
                      || (i_req.addr == pwo_pkg::ADDR_OFFSET_TRIM_HIGH);
  assign write_open = i_req.write && !i_init_done; // [R1]
  assign locked_write = i_req.write && i_init_done && locked_target; // [R1]

  assign wr_cfg = i_req.write && (i_req.addr == pwo_pkg::ADDR_IRQ_CONFIG);
  assign wr_trim_lo = write_open && (i_req.addr == pwo_pkg::ADDR_OFFSET_TRIM_LOW);
  assign wr_trim_hi = write_open && (i_req.addr == pwo_pkg::ADDR_OFFSET_TRIM_HIGH);

  always_comb begin
    offset_trim_next = offset_trim_reg;
    if (wr_trim_lo) begin
      offset_trim_next[7:0] = i_req.wdata;
    end
    if (wr_trim_hi) begin
      offset_trim_next[15:8] = i_req.wdata;
    end
  end

  // Rewriting the same value leaves the data path running
  assign trim_changed = (offset_trim_next != offset_trim_reg); // [R7]

  // ------------------------------------------------------------
  // Configuration, limits and trim
  // ------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      irq_config_reg <= pwo_pkg::RESET_CONFIG;
    end else if (wr_cfg) begin
      irq_config_reg <= i_req.wdata & 8'h38;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      upper_limit_reg <= {pwo_pkg::RESET_BYTE, pwo_pkg::RESET_BYTE}; // [R15]
      lower_limit_reg <= {pwo_pkg::RESET_BYTE, pwo_pkg::RESET_BYTE}; // [R15]
    end else if (write_open) begin
      case (i_req.addr)
        pwo_pkg::ADDR_UPPER_LIMIT_LOW: upper_limit_reg[7:0] <= i_req.wdata; // [R3]
        pwo_pkg::ADDR_UPPER_LIMIT_HIGH: upper_limit_reg[15:8] <= i_req.wdata; // [R3]
        pwo_pkg::ADDR_LOWER_LIMIT_LOW: lower_limit_reg[7:0] <= i_req.wdata; // [R3]
        pwo_pkg::ADDR_LOWER_LIMIT_HIGH: lower_limit_reg[15:8] <= i_req.wdata; // [R3]
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      offset_trim_reg <= {pwo_pkg::RESET_BYTE, pwo_pkg::RESET_BYTE}; // [R15]
    end else begin
      offset_trim_reg <= offset_trim_next;
    end
  end

  // ------------------------------------------------------------
  // Array checking
  // ------------------------------------------------------------
  // Check byte follows every accepted limit or trim write; a later upset of a stored
  // bit shows as a mismatch against the live fold.
  function automatic logic [7:0] fold(input logic [15:0] a, input logic [15:0] b,
                                      input logic [15:0] c);
    fold = a[7:0] ^ a[15:8] ^ b[7:0] ^ b[15:8] ^ c[7:0] ^ c[15:8];
  endfunction : fold

  logic [7:0] stored_byte;
  always_comb begin
    case (i_req.addr)
      pwo_pkg::ADDR_UPPER_LIMIT_LOW: stored_byte = upper_limit_reg[7:0];
      pwo_pkg::ADDR_UPPER_LIMIT_HIGH: stored_byte = upper_limit_reg[15:8];
      pwo_pkg::ADDR_LOWER_LIMIT_LOW: stored_byte = lower_limit_reg[7:0];
      pwo_pkg::ADDR_LOWER_LIMIT_HIGH: stored_byte = lower_limit_reg[15:8];
      pwo_pkg::ADDR_OFFSET_TRIM_LOW: stored_byte = offset_trim_reg[7:0];
      pwo_pkg::ADDR_OFFSET_TRIM_HIGH: stored_byte = offset_trim_reg[15:8];
      default: stored_byte = 8'h00;
    endcase
  end

  always_comb begin
    check_next = check_reg;
    if (write_open && locked_target) begin
      check_next = check_reg ^ i_req.wdata ^ stored_byte;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      check_reg <= pwo_pkg::RESET_BYTE;
    end else begin
      check_reg <= check_next; // [R2]
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_array_error <= 1'b0;
    end else if (check_reg != fold(upper_limit_reg, lower_limit_reg, offset_trim_reg)) begin
      o_array_error <= 1'b1; // [R2]
    end
  end

  // ------------------------------------------------------------
  // DSP data path and offset trim
  // ------------------------------------------------------------
  logic [31:0] reinit_count_reg;
  logic dsp_ready;
  logic sample_take;

  assign dsp_ready = (reinit_count_reg == 32'h0000_0000);
  assign sample_take = i_sample.valid && dsp_ready && !trim_changed;

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      reinit_count_reg <= 32'h0000_0000;
      o_dsp_path_reset <= 1'b0;
    end else begin
      o_dsp_path_reset <= trim_changed; // [R7]
      if (trim_changed) begin
        reinit_count_reg <= 32'(REINIT_CYCLES); // [R7]
      end else if (!dsp_ready) begin
        reinit_count_reg <= reinit_count_reg - 32'h0000_0001;
      end
    end
  end

  // Valid only after a fresh sample once the path has settled again
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_sensor_result <= 16'h0000;
      o_result_valid <= 1'b0;
    end else if (trim_changed) begin
      o_result_valid <= 1'b0; // [R7]
    end else if (sample_take) begin
      o_sensor_result <= i_sample.pressure + offset_trim_reg; // [R6]
      o_result_valid <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Window comparator
  // ------------------------------------------------------------
  logic [15:0] compared;
  logic above_upper;
  logic below_lower;
  logic both_off;
  logic outside;
  logic condition;
  logic [1:0] stretch_sel;
  logic [31:0] stretch_load;
  logic [31:0] stretch_count_reg;
  logic [31:0] stretch_count_next;

  assign compared = i_sample.pressure + offset_trim_reg; // [R6]
  assign above_upper = (upper_limit_reg != pwo_pkg::LIMIT_OFF)
                    && (compared > upper_limit_reg); // [R4]
  assign below_lower = (lower_limit_reg != pwo_pkg::LIMIT_OFF)
                    && (compared < lower_limit_reg); // [R4]
  assign both_off = (upper_limit_reg == pwo_pkg::LIMIT_OFF)
                 && (lower_limit_reg == pwo_pkg::LIMIT_OFF);
  assign outside = above_upper || below_lower; // [R18]
  assign condition = !both_off && (irq_config_reg[pwo_pkg::CFG_SENSE_BIT] ? !outside
                                                                           : outside); // [R16]
  assign stretch_sel = irq_config_reg[pwo_pkg::CFG_STRETCH_LSB +: 2];

  always_comb begin
    case (stretch_sel)
      2'h1: stretch_load = 32'(STRETCH_1);
      2'h2: stretch_load = 32'(STRETCH_2);
      2'h3: stretch_load = 32'(STRETCH_3);
      default: stretch_load = 32'h0000_0000;
    endcase
  end

  always_comb begin
    stretch_count_next = stretch_count_reg;
    if (both_off || (stretch_sel == 2'h0)) begin
      stretch_count_next = 32'h0000_0000; // [R5]
    end else if (sample_take && condition) begin
      stretch_count_next = stretch_load; // [R17]
    end else if (stretch_count_reg != 32'h0000_0000) begin
      stretch_count_next = stretch_count_reg - 32'h0000_0001;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      stretch_count_reg <= 32'h0000_0000;
    end else begin
      stretch_count_reg <= stretch_count_next;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_interrupt_pin <= 1'b0;
    end else if (both_off) begin
      o_interrupt_pin <= 1'b0; // [R5]
    end else if (stretch_sel == 2'h0) begin
      if (sample_take) begin
        o_interrupt_pin <= condition; // [R17]
      end
    end else begin
      o_interrupt_pin <= (stretch_count_next != 32'h0000_0000); // [R17]
    end
  end

  // ------------------------------------------------------------
  // DSP status flags
  // ------------------------------------------------------------
  logic flags_read;
  logic cm_clear;

  assign selftest_running = |i_selftest_control; // [R11]
  assign flags_read = i_req.read && (i_req.addr == pwo_pkg::ADDR_DSP_FLAGS);
  assign cm_clear = flags_read || i_status_read_other || i_tx_reported_cm; // [R13]

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      selftest_never_run_reg <= pwo_pkg::RESET_DSP_FLAGS[pwo_pkg::FLAG_NEVER_RUN]; // [R10]
    end else if (selftest_running) begin
      selftest_never_run_reg <= 1'b0; // [R10]
    end
  end

  // A fresh excursion in the clearing cycle keeps the flag set
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      common_mode_fault_reg <= pwo_pkg::RESET_DSP_FLAGS[pwo_pkg::FLAG_CM_FAULT];
    end else if (i_cm_out_of_limits) begin
      common_mode_fault_reg <= 1'b1; // [R12]
    end else if (cm_clear) begin
      common_mode_fault_reg <= 1'b0; // [R13]
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      selftest_failure_reg <= pwo_pkg::RESET_DSP_FLAGS[pwo_pkg::FLAG_ST_FAILURE]; // [R15]
    end else if (i_selftest_fail) begin
      selftest_failure_reg <= 1'b1; // [R14]
    end
  end

  // ------------------------------------------------------------
  // Event status, enable and clear
  // ------------------------------------------------------------
  assign event_set[pwo_pkg::EV_WINDOW] = sample_take && condition;
  assign event_set[pwo_pkg::EV_CM_FAULT] = i_cm_out_of_limits && !common_mode_fault_reg;
  assign event_set[pwo_pkg::EV_ST_FAILURE] = i_selftest_fail && !selftest_failure_reg;
  assign event_set[pwo_pkg::EV_LOCKED_WRITE] = locked_write;
  assign event_set[pwo_pkg::EV_ARRAY_ERROR] = !o_array_error
      && (check_reg != fold(upper_limit_reg, lower_limit_reg, offset_trim_reg));
  assign event_clear = (i_req.write && (i_req.addr == pwo_pkg::ADDR_EVENT_CLEAR))
                     ? i_req.wdata[pwo_pkg::EVENT_COUNT-1:0]
                     : '0;

  genvar gi;
  generate
    for (gi = 0; gi < pwo_pkg::EVENT_COUNT; gi++) begin : g_event
      always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
          event_status_reg[gi] <= 1'b0;
        end else if (event_set[gi]) begin
          event_status_reg[gi] <= 1'b1;
        end else if (event_clear[gi]) begin
          event_status_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      event_enable_reg <= '0;
    end else if (i_req.write && (i_req.addr == pwo_pkg::ADDR_EVENT_ENABLE)) begin
      event_enable_reg <= i_req.wdata[pwo_pkg::EVENT_COUNT-1:0];
    end
  end

  assign o_irq = |(event_status_reg & event_enable_reg);

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  // Status register has no write decode, so writes to it fall away
  always_comb begin
    rdata_next = 8'h00;
    if (i_req.read) begin
      case (i_req.addr)
        pwo_pkg::ADDR_IRQ_CONFIG: rdata_next = irq_config_reg;
        pwo_pkg::ADDR_DSP_FLAGS: begin
          rdata_next = {4'h0, selftest_never_run_reg, selftest_running,
                        common_mode_fault_reg, selftest_failure_reg}; // [R19]
        end
        pwo_pkg::ADDR_EVENT_STATUS: rdata_next = 8'(event_status_reg);
        pwo_pkg::ADDR_EVENT_ENABLE: rdata_next = 8'(event_enable_reg);
        default: rdata_next = stored_byte;
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign o_rdata = rdata_reg;

endmodule : pressure_window_offset_status

//--- tb/pwo_monitor.sv
// Port checker of the pressure window, offset trim and status bank
`timescale 1ns/100ps

module pwo_monitor (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire pwo_pkg::reg_req_t i_req,
  input wire logic [7:0] o_rdata,
  input wire logic i_init_done,
  input wire logic [3:0] i_selftest_control,
  input wire logic i_selftest_fail,
  input wire logic i_cm_out_of_limits,
  input wire logic i_status_read_other,
  input wire logic i_tx_reported_cm,
  input wire pwo_pkg::sample_t i_sample,
  input wire logic [15:0] o_sensor_result,
  input wire logic o_result_valid,
  input wire logic o_dsp_path_reset
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);

  logic rd_flags;
  logic trim_wr;
  logic cm_kept;
  assign rd_flags = i_req.read && i_req.addr == pwo_pkg::ADDR_DSP_FLAGS;
  assign cm_kept = !rd_flags && !i_status_read_other && !i_tx_reported_cm;
  assign trim_wr = i_req.write && (i_req.addr == pwo_pkg::ADDR_OFFSET_TRIM_LOW ||
                                   i_req.addr == pwo_pkg::ADDR_OFFSET_TRIM_HIGH);

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  rdata_idle_a: assert property (!i_req.read |=> o_rdata == 8'h00)
    else $error("read data not zero outside a read");
  reserved_zero_a: assert property (rd_flags |=> o_rdata[7:4] == 4'h0)
    else $error("flag register upper bits not zero");
  running_or_a: assert property (rd_flags |=> o_rdata[2] == ($past(i_selftest_control) != 4'h0))
    else $error("running flag differs from control bits");
  cm_set_a: assert property (i_cm_out_of_limits ##1 cm_kept ##1 rd_flags |=> o_rdata[1])
    else $error("common mode fault not reported");
  st_fail_a: assert property (i_selftest_fail ##2 rd_flags |=> o_rdata[0])
    else $error("self-test failure not reported");
  never_run_a: assert property ((i_selftest_control != 4'h0) ##1 rd_flags |=> !o_rdata[3])
    else $error("never-run flag still set after self-test");
  reinit_block_a: assert property (o_dsp_path_reset |-> !o_result_valid [*6])
    else $error("result valid during reinitialisation");
  locked_trim_a: assert property (i_init_done && trim_wr |=> !o_dsp_path_reset)
    else $error("locked trim write reset the data path");
  result_hold_a: assert property (!i_sample.valid |=> $stable(o_sensor_result))
    else $error("result changed without a sample");
  valid_cause_a: assert property ($rose(o_result_valid) |-> $past(i_sample.valid))
    else $error("result became valid without a sample");
endmodule : pwo_monitor

bind pressure_window_offset_status pwo_monitor pwo_monitor_inst (
  .i_clock(i_clock),
  .i_reset(i_reset),
  .i_req(i_req),
  .o_rdata(o_rdata),
  .i_init_done(i_init_done),
  .i_selftest_control(i_selftest_control),
  .i_selftest_fail(i_selftest_fail),
  .i_cm_out_of_limits(i_cm_out_of_limits),
  .i_status_read_other(i_status_read_other),
  .i_tx_reported_cm(i_tx_reported_cm),
  .i_sample(i_sample),
  .o_sensor_result(o_sensor_result),
  .o_result_valid(o_result_valid),
  .o_dsp_path_reset(o_dsp_path_reset)
);

//--- tb/host_model.sv
// Register-bus master standing in for the host controller
`timescale 1ns/100ps

module host_model #(
  parameter int REINIT_WAIT = 12
) (
  input wire logic i_clock,
  input wire logic [7:0] i_rdata,
  output pwo_pkg::reg_req_t o_req
);
  initial o_req = '0;

  // Released address and data show inverted values, never the last ones
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge i_clock);
    o_req <= {1'b1, 1'b0, addr, data};
    @(posedge i_clock);
    o_req <= {1'b0, 1'b0, ~addr, ~data};
  endtask : write_reg

  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge i_clock);
    o_req <= {1'b0, 1'b1, addr, 8'h00};
    @(posedge i_clock);
    o_req <= {1'b0, 1'b0, ~addr, 8'hFF};
    #1;
    data = i_rdata;
  endtask : read_reg

  // Stay off the result while the data path reinitialises
  task automatic settle;
    repeat (REINIT_WAIT) @(posedge i_clock);
  endtask : settle
endmodule : host_model

//--- tb/testbench.sv
// Self-checking bench of the pressure window, offset trim and status bank
`timescale 1ns/100ps

module testbench;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  pwo_pkg::reg_req_t req;
  pwo_pkg::sample_t sample = '0;
  logic [7:0] rdata;
  logic init_done = 1'b0;
  logic [3:0] selftest_control_field = 4'h0;
  logic st_fail = 1'b0;
  logic cm_out = 1'b0;
  logic read_other = 1'b0;
  logic tx_cm = 1'b0;
  logic [15:0] result;
  logic valid, path_reset, pin, arr_err, irq;
  int err_total = 0;
  int total_checks = 0;

  always #5 i_clock = ~i_clock;

  host_model host_model_inst (.i_clock(i_clock), .i_rdata(rdata), .o_req(req));

  pressure_window_offset_status #(.STRETCH_1(20), .STRETCH_2(40), .STRETCH_3(80),
    .REINIT_CYCLES(8)) pressure_window_offset_status_inst (
    .i_clock(i_clock), .i_reset(i_reset), .i_req(req), .o_rdata(rdata),
    .i_init_done(init_done), .i_selftest_control(selftest_control_field), .i_selftest_fail(st_fail),
    .i_cm_out_of_limits(cm_out), .i_status_read_other(read_other),
    .i_tx_reported_cm(tx_cm), .i_sample(sample), .o_sensor_result(result),
    .o_result_valid(valid), .o_dsp_path_reset(path_reset), .o_interrupt_pin(pin),
    .o_array_error(arr_err), .o_irq(irq));

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_model_inst.write_reg(a, d);
  endtask : wr

  task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host_model_inst.read_reg(a, d);
    check({a, d}, {a, exp}, "register read");
  endtask : expect_reg

  task automatic pin_after(input logic [15:0] p, input logic exp);
    @(posedge i_clock);
    sample <= {1'b1, p};
    @(posedge i_clock);
    sample <= {1'b0, ~p};
    #1;
    check(16'(pin), 16'(exp), "interrupt pin");
  endtask : pin_after

  // Drives a one-cycle pulse on one of the status event inputs
  task automatic pulse(input int which);
    @(posedge i_clock);
    case (which)
      0: cm_out <= 1'b1;
      1: tx_cm <= 1'b1;
      2: read_other <= 1'b1;
      default: st_fail <= 1'b1;
    endcase
    @(posedge i_clock);
    {cm_out, tx_cm, read_other, st_fail} <= 4'h0;
    #1;
  endtask : pulse

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_reset_values;
    logic [7:0] map[7] = '{8'h45, 8'h46, 8'h47, 8'h48, 8'h49, 8'h4C, 8'h4D};
    foreach (map[i]) expect_reg(map[i], 8'h00);
    expect_reg(8'h60, 8'h08);
    wr(8'h60, 8'hFF);
    expect_reg(8'h60, 8'h08);
    expect_reg(8'h55, 8'h00);
    check(16'(arr_err), 16'h0000, "array error");
  endtask : t_reset_values

  task automatic t_window;
    wr(8'h46, 8'hE8);
    wr(8'h47, 8'h03);
    expect_reg(8'h47, 8'h03);
    pin_after(16'h0400, 1'b1);
    pin_after(16'h0100, 1'b0);
    wr(8'h46, 8'h00);
    wr(8'h47, 8'h00);
    wr(8'h49, 8'h02);
    pin_after(16'h0100, 1'b1);
    pin_after(16'h0300, 1'b0);
    wr(8'h45, 8'h08);
    pin_after(16'h0300, 1'b1);
    pin_after(16'h0100, 1'b0);
    wr(8'h49, 8'h00);
    pin_after(16'h0300, 1'b0);
    wr(8'h45, 8'h10);
    wr(8'h49, 8'h02);
    pin_after(16'h0100, 1'b1);
    pin_after(16'h0300, 1'b1);
    repeat (25) @(posedge i_clock);
    #1;
    check(16'(pin), 16'h0000, "stretched pin");
    wr(8'h45, 8'h20);
    pin_after(16'h0100, 1'b1);
    repeat (30) @(posedge i_clock);
    #1;
    check(16'(pin), 16'h0001, "longer stretch");
    wr(8'h45, 8'h00);
  endtask : t_window

  // Trim of -2 takes a sample of 0001h past the lower rail, wrapping the result to FFFFh
  task automatic t_trim;
    wr(8'h4C, 8'hFE);
    #1;
    check({15'h0000, path_reset}, 16'h0001, "path reset pulse");
    check(16'(valid), 16'h0000, "valid after trim");
    wr(8'h4D, 8'hFF);
    host_model_inst.settle();
    pin_after(16'h1000, 1'b0);
    check(result, 16'h0FFE, "trimmed result");
    check(16'(valid), 16'h0001, "valid after settle");
    pin_after(16'h0001, 1'b0);
    check(result, 16'hFFFF, "wrapped result");
    expect_reg(8'h4D, 8'hFF);
    wr(8'h4C, 8'hFE);
    #1;
    check(16'(path_reset), 16'h0000, "equal rewrite");
  endtask : t_trim

  task automatic t_flags;
    wr(8'h72, 8'hFF);
    wr(8'h71, 8'h02);
    pulse(0);
    check(16'(irq), 16'h0001, "irq raised");
    expect_reg(8'h60, 8'h0A);
    expect_reg(8'h60, 8'h08);
    expect_reg(8'h70, 8'h02);
    wr(8'h72, 8'h02);
    #1;
    check(16'(irq), 16'h0000, "irq cleared");
    for (int k = 1; k < 3; k++) begin
      pulse(0);
      pulse(k);
      expect_reg(8'h60, 8'h08);
    end
    wr(8'h71, 8'h00);
    pulse(0);
    check(16'(irq), 16'h0000, "irq masked");
    pulse(3);
    expect_reg(8'h60, 8'h0B);
    for (int b = 0; b < 4; b++) begin
      @(posedge i_clock);
      selftest_control_field <= 4'(1 << b);
      expect_reg(8'h60, 8'h05);
    end
    @(posedge i_clock);
    selftest_control_field <= 4'h0;
    expect_reg(8'h60, 8'h01);
  endtask : t_flags

  task automatic t_lock;
    wr(8'h72, 8'hFF);
    @(posedge i_clock);
    init_done <= 1'b1;
    wr(8'h46, 8'h55);
    wr(8'h4C, 8'h12);
    expect_reg(8'h46, 8'h00);
    expect_reg(8'h4C, 8'hFE);
    expect_reg(8'h70, 8'h08);
    check(16'(arr_err), 16'h0000, "array error");
  endtask : t_lock

  // ----------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (4) @(posedge i_clock);
    i_reset <= 1'b0;
    t_reset_values();
    t_window();
    t_trim();
    t_flags();
    t_lock();
    tally_and_finish();
  end

  // Whole run needs well under two thousand cycles
  initial begin
    #100000;
    err_total++;
    tally_and_finish();
  end
endmodule : testbench
